// file: hdl/usart_consts.vh
// Purpose: constants of the serial port control block
// Assumes: byte addresses on an 8-bit AHB-Lite address
// Notes: definitions only
`ifndef USART_CONSTS_VH
`define USART_CONSTS_VH

// ****************************************
// register byte addresses
// ****************************************
`define ADDR_RX_CTRL 8'h18
`define ADDR_TX_DATA 8'h1C
`define ADDR_RX_DATA 8'h20
`define ADDR_PORT_DIR 8'h24
`define ADDR_INT_STATUS 8'h28
`define ADDR_INT_MASK 8'h2C
`define ADDR_TX_CTRL 8'h98
`define ADDR_BAUD_DIV 8'h9C

// ****************************************
// transmit control fields
// ****************************************
`define TX_CLK_SRC 7
`define TX_WIDTH 6
`define TX_ENABLE 5
`define TX_SYNC 4
`define TX_HIGH_SPEED 2
`define TX_SHIFT_EMPTY 1
`define TX_NINTH 0

// ****************************************
// receive control fields
// ****************************************
`define RX_PORT_EN 7
`define RX_WIDTH 6
`define RX_SINGLE 5
`define RX_CONT 4
`define RX_ADDR_DET 3
`define RX_FRAME_ERR 2
`define RX_OVERRUN 1
`define RX_NINTH 0

// ****************************************
// interrupt status fields and resets
// ****************************************
`define INT_RX_LOADED 0
`define INT_TX_TAKEN 1
`define INT_FRAME 2
`define INT_OVERRUN 3
`define PORT_DIR_RESET 8'hFF
`define BAUD_DIV_RESET 8'h00

// ****************************************
// baud ticks per bit
// ****************************************
`define BIT_TICKS_LOW 7'h40
`define BIT_TICKS_HIGH 7'h10
`define BIT_TICKS_SYNC 7'h04

`endif

// file: hdl/usart_control.v
// Purpose: serial port control, status and baud generation behind AHB-Lite
// Assumes: all inputs synchronous to MCLK; whole-word single transfers
// Notes: pin outputs are registered, so they lag internal state by one clock
//
// Notes on behaviour
// - pins act as serial pins only with port enable and both direction bits set.
// - in synchronous mode clock source 1 means master clocking, 0 means slave.
// - transmit width bit selects nine-bit frames; ninth bit from its own bit.
// - mode select bit 1 gives synchronous, 0 asynchronous operation.
// - high speed bit picks divide by 16 versus 64, asynchronous only.
// - shift register empty status is read only and resets to one.
// - synchronous receive enables override transmit enable.
// - single receive starts one master reception; hardware clears it after.
// - continuous receive runs until cleared or an overrun stops it; overrides single receive.
// - nine-bit async address detect accepts only characters with ninth bit set.
// - framing error is read only, updated when a character loads the buffer.
// - overrun error clears only by clearing continuous receive.
// - receive width bit selects nine-bit reception; ninth bit shown in status.
// - baud generator is a free running 8-bit timer, period divisor plus one.
// - writing the divisor clears the baud timer at once.
// - async low speed bit rate is clock over 64 times divisor plus one.
// - async high speed bit rate is clock over 16 times divisor plus one.
// - master shift clock is clock over 4 times divisor plus one.
`timescale 1ns/1ps
`include "usart_consts.vh"

module usart_control (
    input wire MCLK,
    input wire NRST,
    input wire HSEL,
    input wire [7:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire HREADY,
    input wire [31:0] HWDATA,
    output reg [31:0] HRDATA,
    output reg HREADYOUT,
    output reg HRESP,
    input wire CK_I,
    output reg CK_O,
    output reg CK_OE,
    input wire DT_I,
    output reg DT_O,
    output reg DT_OE,
    output reg IRQ
);

// ****************************************
// state
// ****************************************
reg clock_source_select, tx_width_select, tx_enable, sync_mode, high_speed_select;
reg tx_ninth_bit;
reg serial_port_enable, rx_width_select, single_receive_enable;
reg continuous_receive_enable, address_detect_enable;
reg framing_error_flag, overrun_error_flag, rx_ninth_bit;
reg [7:0] baud_divisor;
reg [7:0] portb_direction;
reg [7:0] brg_cnt;
reg [7:0] tx_hold;
reg tx_full;
reg [7:0] receive_data_register;
reg rx_full;
reg [3:0] int_status;
reg [3:0] int_mask;
reg [10:0] transmit_shift_register;
reg [3:0] tx_left;
reg [5:0] tx_tick;
reg [10:0] receive_shift_register;
reg [3:0] rx_left;
reg [5:0] rx_tick;
reg ck_gen, ck_ph, ck_prev;
reg wr_pend, rd_pend;
reg [7:0] wr_addr, rd_addr;

// ****************************************
// modes and timing
// ****************************************
wire pins_on = serial_port_enable & portb_direction[2] & portb_direction[1];
wire master = sync_mode & clock_source_select;
wire brg_tick = (brg_cnt == baud_divisor);
// bit time in baud ticks; high speed bit has no say in synchronous mode
wire [6:0] nbit = sync_mode ? `BIT_TICKS_SYNC :
    (high_speed_select ? `BIT_TICKS_HIGH : `BIT_TICKS_LOW);
wire [5:0] last_tick = nbit[5:0] - 6'h01;
// single receive only counts for a synchronous master
wire rx_en = sync_mode ? (continuous_receive_enable | (single_receive_enable & master)) :
    continuous_receive_enable;
wire tx_allowed = tx_enable & ~(sync_mode & rx_en);
wire rx_on = pins_on & rx_en & ~overrun_error_flag;
wire tx_busy = (tx_left != 4'h0);

// serial clock edges: own generator as master, pin edges as slave
wire gen_rise = brg_tick & ck_ph & ~ck_gen;
wire gen_fall = brg_tick & ck_ph & ck_gen;
wire sclk_rise = master ? gen_rise : (CK_I & ~ck_prev);
wire sclk_fall = master ? gen_fall : (~CK_I & ck_prev);
wire sclk_run = master & pins_on & ((tx_busy & tx_allowed) | rx_on);

wire tx_step = sync_mode ? sclk_fall : (brg_tick & (tx_tick == last_tick));
wire rx_samp = sync_mode ? sclk_rise : (brg_tick & (rx_tick == last_tick));
wire tx_go = pins_on & tx_allowed & tx_full & ~tx_busy;
wire [3:0] rx_total = sync_mode ? (rx_width_select ? 4'h9 : 4'h8) :
    (rx_width_select ? 4'hB : 4'hA);
wire rx_busy = (rx_left != 4'h0);
wire rx_last = rx_on & rx_busy & rx_samp & (rx_left == 4'h1);
// a high start sample is line noise, not a character
wire false_start = ~sync_mode & rx_busy & rx_samp & (rx_left == rx_total) & DT_I;
wire [10:0] frame = {DT_I, receive_shift_register[10:1]};

// ****************************************
// bus decode
// ****************************************
wire bus_take = HSEL & HTRANS[1] & HREADY;
wire rd_rx = rd_pend & (rd_addr == `ADDR_RX_DATA);

reg [7:0] rx_data;
reg rx_n9, rx_fe;
always @* begin
    rx_data = frame[9:2];
    rx_n9 = 1'b0;
    rx_fe = 1'b0;
    case ({sync_mode, rx_width_select})
        2'b01: begin
            rx_data = frame[8:1];
            rx_n9 = frame[9];
            rx_fe = ~frame[10];
        end
        2'b00: begin
            rx_fe = ~frame[10];
        end
        2'b11: begin
            rx_n9 = frame[10];
        end
        2'b10: begin
            rx_data = frame[10:3];
        end
        default: begin
            rx_data = frame[9:2];
        end
    endcase
end

// address detect drops characters with a clear ninth bit
wire accept = rx_last & ~(~sync_mode & rx_width_select & address_detect_enable & ~rx_n9);
wire loadable = ~rx_full | rd_rx;
wire rx_ev = accept & loadable;
wire ov_ev = accept & ~loadable;
wire [3:0] events = {ov_ev, rx_ev & rx_fe, tx_go, rx_ev};

reg [7:0] rd_mux;
always @* begin
    case (rd_addr)
        `ADDR_TX_CTRL: rd_mux = {clock_source_select, tx_width_select, tx_enable,
            sync_mode, 1'b0, high_speed_select, ~tx_busy, tx_ninth_bit};
        `ADDR_RX_CTRL: rd_mux = {serial_port_enable, rx_width_select,
            single_receive_enable, continuous_receive_enable, address_detect_enable,
            framing_error_flag, overrun_error_flag, rx_ninth_bit};
        `ADDR_BAUD_DIV: rd_mux = baud_divisor;
        `ADDR_TX_DATA: rd_mux = tx_hold;
        `ADDR_RX_DATA: rd_mux = receive_data_register;
        `ADDR_PORT_DIR: rd_mux = portb_direction;
        `ADDR_INT_STATUS: rd_mux = {4'h0, int_status};
        `ADDR_INT_MASK: rd_mux = {4'h0, int_mask};
        default: rd_mux = 8'h00;
    endcase
end

// ****************************************
// bus slave and registers
// ****************************************
always @(posedge MCLK) begin
    if (!NRST) begin
        HRDATA <= 32'h00000000;
        HREADYOUT <= 1'b1;
        HRESP <= 1'b0;
        wr_pend <= 1'b0;
        rd_pend <= 1'b0;
        wr_addr <= 8'h00;
        rd_addr <= 8'h00;
        clock_source_select <= 1'b0;
        tx_width_select <= 1'b0;
        tx_enable <= 1'b0;
        sync_mode <= 1'b0;
        high_speed_select <= 1'b0;
        tx_ninth_bit <= 1'b0;
        serial_port_enable <= 1'b0;
        rx_width_select <= 1'b0;
        single_receive_enable <= 1'b0;
        continuous_receive_enable <= 1'b0;
        address_detect_enable <= 1'b0;
        baud_divisor <= `BAUD_DIV_RESET;
        portb_direction <= `PORT_DIR_RESET;
        tx_hold <= 8'h00;
        tx_full <= 1'b0;
        int_mask <= 4'h0;
        int_status <= 4'h0;
    end else begin
        HRESP <= 1'b0;
        wr_pend <= bus_take & HWRITE;
        rd_pend <= bus_take & ~HWRITE;
        if (bus_take) begin
            wr_addr <= HADDR;
            rd_addr <= HADDR;
        end
        // reads take one wait state so a write just before is visible
        if (bus_take & ~HWRITE) begin
            HREADYOUT <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
        end
        if (rd_pend) begin
            HRDATA <= {24'h000000, rd_mux};
        end
        if (tx_go) begin
            tx_full <= 1'b0;
        end
        if (wr_pend) begin
            case (wr_addr)
                `ADDR_TX_CTRL: begin
                    clock_source_select <= HWDATA[`TX_CLK_SRC];
                    tx_width_select <= HWDATA[`TX_WIDTH];
                    tx_enable <= HWDATA[`TX_ENABLE];
                    sync_mode <= HWDATA[`TX_SYNC];
                    high_speed_select <= HWDATA[`TX_HIGH_SPEED];
                    tx_ninth_bit <= HWDATA[`TX_NINTH];
                end
                `ADDR_RX_CTRL: begin
                    serial_port_enable <= HWDATA[`RX_PORT_EN];
                    rx_width_select <= HWDATA[`RX_WIDTH];
                    single_receive_enable <= HWDATA[`RX_SINGLE];
                    continuous_receive_enable <= HWDATA[`RX_CONT];
                    address_detect_enable <= HWDATA[`RX_ADDR_DET];
                end
                `ADDR_BAUD_DIV: baud_divisor <= HWDATA[7:0];
                `ADDR_PORT_DIR: portb_direction <= HWDATA[7:0];
                `ADDR_INT_MASK: int_mask <= HWDATA[3:0];
                `ADDR_TX_DATA: begin
                    // a full holding register drops the new byte
                    if (!tx_full | tx_go) begin
                        tx_hold <= HWDATA[7:0];
                        tx_full <= 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        // hardware clear follows the software write in the same cycle
        if (rx_last & master) begin
            single_receive_enable <= 1'b0;
        end
        // set wins over the write-one clear
        if (wr_pend & (wr_addr == `ADDR_INT_STATUS)) begin
            int_status <= (int_status & ~HWDATA[3:0]) | events;
        end else begin
            int_status <= int_status | events;
        end
    end
end

// ****************************************
// baud generator
// ****************************************
always @(posedge MCLK) begin
    if (!NRST) begin
        brg_cnt <= 8'h00;
    end else if (wr_pend & (wr_addr == `ADDR_BAUD_DIV)) begin
        brg_cnt <= 8'h00;
    end else if (brg_tick) begin
        brg_cnt <= 8'h00;
    end else begin
        brg_cnt <= brg_cnt + 8'h01;
    end
end

// ****************************************
// serial clock
// ****************************************
always @(posedge MCLK) begin
    if (!NRST) begin
        ck_gen <= 1'b0;
        ck_ph <= 1'b0;
        ck_prev <= 1'b0;
    end else begin
        ck_prev <= CK_I;
        // a started clock always finishes back low
        if (brg_tick & (sclk_run | ck_gen)) begin
            ck_ph <= ~ck_ph;
            if (ck_ph) begin
                ck_gen <= ~ck_gen;
            end
        end else if (!sclk_run & !ck_gen) begin
            ck_ph <= 1'b0;
        end
    end
end

// ****************************************
// transmitter
// ****************************************
always @(posedge MCLK) begin
    if (!NRST) begin
        transmit_shift_register <= 11'h7FF;
        tx_left <= 4'h0;
        tx_tick <= 6'h00;
    end else if (!pins_on) begin
        tx_left <= 4'h0;
        transmit_shift_register <= 11'h7FF;
    end else if (tx_go) begin
        tx_tick <= 6'h00;
        if (sync_mode) begin
            transmit_shift_register <= {2'b11, tx_ninth_bit, tx_hold};
            tx_left <= tx_width_select ? 4'h9 : 4'h8;
        end else begin
            transmit_shift_register <= {1'b1, tx_width_select ? tx_ninth_bit : 1'b1,
                tx_hold, 1'b0};
            tx_left <= tx_width_select ? 4'hB : 4'hA;
        end
    end else if (tx_busy) begin
        if (!sync_mode & brg_tick) begin
            tx_tick <= (tx_tick == last_tick) ? 6'h00 : tx_tick + 6'h01;
        end
        if (tx_step & (tx_allowed | ~sync_mode)) begin
            transmit_shift_register <= {1'b1, transmit_shift_register[10:1]};
            tx_left <= tx_left - 4'h1;
        end
    end
end

// ****************************************
// receiver
// ****************************************
always @(posedge MCLK) begin
    if (!NRST) begin
        receive_shift_register <= 11'h000;
        rx_left <= 4'h0;
        rx_tick <= 6'h00;
        receive_data_register <= 8'h00;
        rx_full <= 1'b0;
        framing_error_flag <= 1'b0;
        overrun_error_flag <= 1'b0;
        rx_ninth_bit <= 1'b0;
    end else begin
        if (!continuous_receive_enable) begin
            overrun_error_flag <= 1'b0;
        end else if (ov_ev) begin
            overrun_error_flag <= 1'b1;
        end
        if (rd_rx) begin
            rx_full <= 1'b0;
        end
        if (rx_ev) begin
            receive_data_register <= rx_data;
            rx_full <= 1'b1;
            rx_ninth_bit <= rx_n9;
            framing_error_flag <= rx_fe;
        end
        if (!rx_on | false_start | rx_last) begin
            rx_left <= 4'h0;
        end else if (!rx_busy) begin
            // async waits for a low start bit; sync starts at once
            if (sync_mode | ~DT_I) begin
                rx_left <= rx_total;
                rx_tick <= nbit[6:1];
            end
        end else begin
            if (!sync_mode & brg_tick) begin
                rx_tick <= (rx_tick == last_tick) ? 6'h00 : rx_tick + 6'h01;
            end
            if (rx_samp) begin
                receive_shift_register <= frame;
                rx_left <= rx_left - 4'h1;
            end
        end
    end
end

// ****************************************
// pins and interrupt
// ****************************************
always @(posedge MCLK) begin
    if (!NRST) begin
        CK_O <= 1'b1;
        CK_OE <= 1'b0;
        DT_O <= 1'b1;
        DT_OE <= 1'b0;
        IRQ <= 1'b0;
    end else begin
        CK_OE <= pins_on & (~sync_mode | master);
        CK_O <= sync_mode ? ck_gen : (tx_busy ? transmit_shift_register[0] : 1'b1);
        DT_OE <= pins_on & sync_mode & tx_busy & tx_allowed;
        DT_O <= transmit_shift_register[0];
        IRQ <= |(int_status & int_mask);
    end
end

endmodule // usart_control

// file: verif/serial_peer.sv
// Purpose: far side model, terminal on the async line or sync peripheral
// Assumes: bench sets bit_len, nbits and listen before traffic
// Notes: behavioural; samples mid-bit so the one clock pin lag is harmless
`timescale 1ns/1ps
module serial_peer (
    input wire clk,
    input wire ck_o,
    input wire ck_oe,
    input wire dt_o,
    input wire dt_oe,
    output reg line
);
    integer bit_len = 16;
    integer nbits = 8;
    integer frames = 0;
    integer sync_cnt = 0;
    integer idx = 8;
    integer i;
    reg listen = 1'b0;
    reg ck_d = 1'b0;
    reg [8:0] got = 9'h000;
    reg [8:0] sync_word = 9'h000;
    reg [7:0] sbyte = 8'h00;
    initial line = 1'b1;
    // ****************************************
    // async capture, lsb first
    // ****************************************
    always begin
        @(posedge clk);
        if (listen && ck_oe && !ck_o) begin
            got = 9'h000;
            repeat (bit_len / 2) @(posedge clk);
            for (i = 0; i < nbits; i = i + 1) begin
                repeat (bit_len) @(posedge clk);
                got[i] = ck_o;
            end
            repeat (bit_len) @(posedge clk);
            frames = frames + 1;
        end
    end
    // ****************************************
    // sync: take on clock rise, present after fall
    // ****************************************
    always @(posedge clk) begin
        ck_d <= ck_o;
        if (ck_oe && dt_oe && ck_o && !ck_d) begin
            sync_word[sync_cnt] <= dt_o;
            sync_cnt <= sync_cnt + 1;
        end
    end
    // present at the pin fall itself; the block samples one clock before its pin rises
    always @(negedge ck_o) begin
        if (ck_oe && !dt_oe && idx < 8) begin
            line <= sbyte[idx];
            idx <= idx + 1;
        end
    end
    // start low, n bits lsb first, stop, then idle high
    task send(input [8:0] v, input integer n, input stop_bit);
        integer k;
        begin
            @(posedge clk);
            line <= 1'b0;
            for (k = 0; k <= n; k = k + 1) begin
                repeat (bit_len) @(posedge clk);
                line <= (k == n) ? stop_bit : v[k];
            end
            repeat (bit_len) @(posedge clk);
            line <= 1'b1;
            repeat (bit_len) @(posedge clk);
        end
    endtask
    task arm(input [7:0] v);
        begin
            @(posedge clk);
            line <= v[0];
            sbyte <= v;
            idx <= 1;
        end
    endtask
endmodule // serial_peer

// file: verif/test_usart_control_and_baud_generator.sv
// Purpose: register level test of the serial port control block
// Assumes: one AHB-Lite master, one slave, HREADY tied to HREADYOUT
// Notes: expectations follow the register layout, not the design
`timescale 1ns/1ps
module test_usart_control_and_baud_generator;
    reg mclk = 1'b0;
    reg nrst = 1'b0;
    reg hsel = 1'b0;
    reg [7:0] haddr = 8'h00;
    reg [1:0] htrans = 2'h0;
    reg hwrite = 1'b0;
    reg [31:0] hwdata = 32'h00000000;
    reg ck_i = 1'b0;
    wire [31:0] hrdata;
    wire hreadyout, hresp, ck_o, ck_oe, dt_i, dt_o, dt_oe, irq;
    reg [31:0] r;
    integer n_mismatch = 0;
    integer checked = 0;
    integer cycles = 0;
    integer k;
    usart_control dut (.MCLK(mclk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HREADY(hreadyout), .HWDATA(hwdata),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .CK_I(ck_i),
        .CK_O(ck_o), .CK_OE(ck_oe), .DT_I(dt_i), .DT_O(dt_o), .DT_OE(dt_oe), .IRQ(irq));
    serial_peer peer (.clk(mclk), .ck_o(ck_o), .ck_oe(ck_oe), .dt_o(dt_o),
        .dt_oe(dt_oe), .line(dt_i));
    initial forever #10 mclk = ~mclk;
    // ****************************************
    // bus tasks and compare
    // ****************************************
    task bus(input [7:0] a, input w, input [7:0] d);
        begin
            @(posedge mclk);
            hsel <= 1'b1;
            htrans <= 2'h2;
            hwrite <= w;
            haddr <= a;
            do @(posedge mclk); while (hreadyout !== 1'b1);
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= {24'h000000, d};
            do @(posedge mclk); while (hreadyout !== 1'b1);
            r = hrdata;
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        bus(a, 1'b1, d);
    endtask
    task cmp(input [31:0] got, input [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task rd(input [7:0] a, input [31:0] exp);
        begin
            bus(a, 1'b0, 8'h00);
            cmp(r, exp);
        end
    endtask
    task tx_frame(input [7:0] d, input [8:0] exp);
        begin
            k = peer.frames;
            wr(8'h1C, d);
            while (peer.frames == k) @(posedge mclk);
            cmp({23'h0, peer.got}, {23'h0, exp});
        end
    endtask
    task tally_and_finish;
        begin
            if (n_mismatch == 0 && checked > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    // hang guard, whole run needs well under this
    always @(posedge mclk) begin
        cycles = cycles + 1;
        if (cycles == 40000) begin
            n_mismatch = n_mismatch + 1;
            tally_and_finish;
        end
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        rd(8'h98, 32'h02);
        rd(8'h18, 32'h00);
        rd(8'h9C, 32'h00);
        rd(8'h40, 32'h00);
        wr(8'h98, 8'hFF);
        rd(8'h98, 32'hF7);
        wr(8'h98, 8'h30);
        wr(8'h18, 8'h80);
        repeat (3) @(posedge mclk);
        cmp(ck_oe, 1'b0);
        wr(8'h98, 8'h24);
        repeat (3) @(posedge mclk);
        cmp(ck_oe, 1'b1);
        wr(8'h24, 8'hF9);
        repeat (3) @(posedge mclk);
        cmp(ck_oe, 1'b0);
        wr(8'h24, 8'hFF);
        wr(8'h18, 8'h90);
        peer.listen = 1'b1;
        tx_frame(8'hA5, 9'h0A5);
        wr(8'h98, 8'h65);
        peer.nbits = 9;
        tx_frame(8'h3C, 9'h13C);
        wr(8'h9C, 8'h01);
        wr(8'h98, 8'h20);
        peer.nbits = 8;
        peer.bit_len = 128;
        tx_frame(8'h5A, 9'h05A);
        peer.bit_len = 16;
        wr(8'h9C, 8'h00);
        wr(8'h98, 8'h24);
        wr(8'h28, 8'h0F);
        wr(8'h2C, 8'h01);
        peer.send(9'h03C, 8, 1'b1);
        cmp(irq, 1'b1);
        rd(8'h28, 32'h01);
        rd(8'h20, 32'h3C);
        wr(8'h28, 8'h01);
        repeat (2) @(posedge mclk);
        cmp(irq, 1'b0);
        wr(8'h2C, 8'h00);
        peer.send(9'h011, 8, 1'b0);
        cmp(irq, 1'b0);
        rd(8'h18, 32'h94);
        rd(8'h20, 32'h11);
        peer.send(9'h022, 8, 1'b1);
        rd(8'h18, 32'h90);
        rd(8'h20, 32'h22);
        peer.send(9'h001, 8, 1'b1);
        peer.send(9'h002, 8, 1'b1);
        rd(8'h18, 32'h92);
        rd(8'h20, 32'h01);
        wr(8'h18, 8'h80);
        rd(8'h18, 32'h80);
        wr(8'h18, 8'hD8);
        wr(8'h28, 8'h0F);
        peer.send(9'h055, 9, 1'b1);
        rd(8'h28, 32'h00);
        peer.send(9'h1AA, 9, 1'b1);
        rd(8'h28, 32'h01);
        rd(8'h18, 32'hD9);
        rd(8'h20, 32'hAA);
        peer.listen = 1'b0;
        wr(8'h18, 8'h80);
        wr(8'h98, 8'hB0);
        peer.sync_cnt = 0;
        wr(8'h1C, 8'h96);
        for (k = 0; k < 200 && peer.sync_cnt < 8; k = k + 1) @(posedge mclk);
        cmp({23'h0, peer.sync_word}, 32'h096);
        peer.arm(8'hC3);
        wr(8'h18, 8'hA0);
        wr(8'h1C, 8'h77);
        repeat (4) @(posedge mclk);
        cmp(dt_oe, 1'b0);
        repeat (100) @(posedge mclk);
        rd(8'h18, 32'h80);
        rd(8'h20, 32'hC3);
        tally_and_finish;
    end
endmodule // test_usart_control_and_baud_generator

// file: verif/usart_control_assertions.sv
// Purpose: port level checks of the serial port control block
// Assumes: one clock domain, NRST synchronous and active low
// Notes: sees only the top ports; register state is judged by the bench
`timescale 1ns/1ps
module usart_control_checker (
    input wire MCLK,
    input wire NRST,
    input wire HSEL,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire HREADY,
    input wire [31:0] HRDATA,
    input wire HREADYOUT,
    input wire HRESP,
    input wire CK_O,
    input wire CK_OE,
    input wire DT_O,
    input wire DT_OE,
    input wire IRQ
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!NRST);
    // ****************************************
    // bus sequences
    // ****************************************
    sequence read_taken;
        HSEL && HTRANS[1] && HREADY && !HWRITE;
    endsequence
    sequence write_taken;
        HSEL && HTRANS[1] && HREADY && HWRITE;
    endsequence
    sequence one_wait;
        !HREADYOUT ##1 HREADYOUT;
    endsequence
    // ****************************************
    // assertions
    // ****************************************
    chk_resp_okay: assert property (HRESP == 1'b0)
        else $error("bus response not okay");
    chk_upper_zero: assert property (HRDATA[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    chk_read_wait: assert property (read_taken |=> one_wait)
        else $error("read data phase not one wait cycle");
    chk_write_nowait: assert property (write_taken |=> HREADYOUT)
        else $error("write data phase stalled");
    chk_wait_cause: assert property ($fell(HREADYOUT) |->
        $past(HSEL) && $past(HTRANS[1]) && $past(HREADY) && !$past(HWRITE))
        else $error("wait state without a read");
    chk_rdata_hold: assert property ($past(HREADYOUT) |-> $stable(HRDATA))
        else $error("read data changed outside a read");
    chk_reset_pins: assert property ($rose(NRST) |->
        CK_O && !CK_OE && !DT_OE && !IRQ)
        else $error("pins not idle after reset");
    chk_sync_edge: assert property ($changed(DT_O) && DT_OE && $past(DT_OE) && CK_OE
        |-> !CK_O)
        else $error("sync data changed while clock high");
endmodule // usart_control_checker
bind usart_control usart_control_checker chk (.MCLK(MCLK), .NRST(NRST), .HSEL(HSEL),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CK_O(CK_O), .CK_OE(CK_OE), .DT_O(DT_O),
    .DT_OE(DT_OE), .IRQ(IRQ));
